// [common/crfs_pkg.sv]
package crfs_pkg;

    // =========================================================
    // Geometry of the filter bank and the receive data memory.
    // =========================================================
    localparam int FILTERS      = 256;
    localparam int FRAME_BYTES  = 15;
    localparam int FRAME_BITS   = FRAME_BYTES * 8;
    localparam int KEY_BITS     = 48;
    localparam int CFG_BYTES    = 8;
    localparam int CFG_BITS     = CFG_BYTES * 8;

    // =========================================================
    // Status byte layout and values.
    // =========================================================
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    localparam logic [7:0] STATUS_NEW_ALL  = 8'h3F;
    localparam int         HOST_UNREAD_BIT = 5;
    localparam int         CAN_SCHED_BIT   = 4;
    localparam logic [7:0] HOST_READ_CMD   = 8'h9C;
    localparam logic [3:0] STATUS_OFFS     = 4'h0;

    // =========================================================
    // Table selects on the table write port.
    // =========================================================
    localparam logic [2:0] TBL_MATCH = 3'h0;
    localparam logic [2:0] TBL_MASK  = 3'h1;
    localparam logic [2:0] TBL_FEN   = 3'h2;
    localparam logic [2:0] TBL_IEN   = 3'h3;
    localparam logic [2:0] TBL_CFG   = 3'h4;

    // =========================================================
    // Configuration link timing.
    // =========================================================
    localparam int CLK_PERIOD_NS  = 10;
    localparam int LINK_PERIOD_NS = 125;
    localparam int LINK_HALF_CYC  = (LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1)
                                    / (2 * CLK_PERIOD_NS);

    typedef struct packed {
        logic [31:0] ident;
        logic [7:0]  dlc;
        logic [63:0] data;
        logic [15:0] stamp;
    } crfs_frame_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  sel;
        logic [7:0]  index;
        logic [47:0] data;
    } crfs_tbl_wr_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  cmd;
        logic [7:0]  block;
        logic [3:0]  offs;
    } crfs_host_rd_t;

    typedef struct packed {
        logic [4:0]  who;
        logic [7:0]  block;
        logic [3:0]  offs;
    } crfs_sched_rd_t;

endpackage

// [src/crfs_top.sv]
`timescale 1ns/1ps
module crfs_top
(
    input  wire logic                    clk_sys_i,
    input  wire logic                    rst_i,
    input  wire logic                    run_i,
    input  wire logic                    rx_sck_i,
    input  wire logic                    rx_cs_n_i,
    input  wire logic                    rx_sdi_i,
    output logic                         cfg_sck_o,
    output logic                         cfg_cs_n_o,
    output logic                         cfg_sdo_o,
    input  wire crfs_pkg::crfs_tbl_wr_t  tbl_wr_i,
    input  wire crfs_pkg::crfs_host_rd_t host_rd_i,
    output logic [7:0]                   host_rd_data_o,
    input  wire crfs_pkg::crfs_sched_rd_t sched_rd_i,
    output logic [7:0]                   sched_rd_data_o,
    input  wire logic                    can_int_mask_i,
    input  wire logic                    can_int_clr_i,
    output logic                         can_int_pend_o,
    output logic                         int_o,
    output logic [7:0]                   int_addr_o
);
    import crfs_pkg::*;

    typedef enum logic [1:0] {SCAN_IDLE, SCAN_RUN} crfs_scan_t;

    // =========================================================
    // Pin synchronisers and edge detection.
    // =========================================================
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] last_reg;
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= 4'hE;
            sync2_reg <= 4'hE;
            last_reg  <= 4'hE;
        end
        else
        begin
            sync1_reg <= {rx_cs_n_i, rx_sck_i, rx_sdi_i, run_i};
            sync2_reg <= sync1_reg;
            last_reg  <= sync2_reg;
        end
    end

    wire run_rise  = sync2_reg[0] & ~last_reg[0];
    wire rx_bit    = sync2_reg[1];
    wire sck_rise  = sync2_reg[2] & ~last_reg[2];
    wire cs_active = ~sync2_reg[3];
    wire cs_end    = sync2_reg[3] & ~last_reg[3];

    // =========================================================
    // Frame receiver on the dedicated link.
    // =========================================================
    logic [FRAME_BITS-1:0] rx_shift_reg;
    logic [7:0]            rx_count_reg;
    wire frame_done = cs_end && (rx_count_reg == 8'(FRAME_BITS));
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rx_shift_reg <= '0;
            rx_count_reg <= 8'h00;
        end
        else if (cs_active && sck_rise)
        begin
            rx_shift_reg <= {rx_shift_reg[FRAME_BITS-2:0], rx_bit};
            if (rx_count_reg != 8'hFF)
                rx_count_reg <= rx_count_reg + 8'h01;
        end
        else if (!cs_active)
            rx_count_reg <= 8'h00;
    end

    // =========================================================
    // Tables: match, mask, enables, configuration bytes.
    // =========================================================
    logic [KEY_BITS-1:0] match_mem [FILTERS];
    logic [KEY_BITS-1:0] mask_mem  [FILTERS];
    logic [FILTERS-1:0]  fen_reg;
    logic [FILTERS-1:0]  ien_reg;
    logic [7:0]          cfg_mem   [CFG_BYTES];

    wire tbl_match = tbl_wr_i.valid && (tbl_wr_i.sel == TBL_MATCH);
    wire tbl_mask  = tbl_wr_i.valid && (tbl_wr_i.sel == TBL_MASK);
    wire tbl_fen   = tbl_wr_i.valid && (tbl_wr_i.sel == TBL_FEN);
    wire tbl_ien   = tbl_wr_i.valid && (tbl_wr_i.sel == TBL_IEN);
    wire tbl_cfg   = tbl_wr_i.valid && (tbl_wr_i.sel == TBL_CFG);

    always_ff @(posedge clk_sys_i)
    begin
        if (tbl_match)
            match_mem[tbl_wr_i.index] <= tbl_wr_i.data;
        if (tbl_mask)
            mask_mem[tbl_wr_i.index] <= tbl_wr_i.data;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            fen_reg <= '0;
            ien_reg <= '0;
            for (int i = 0; i < CFG_BYTES; i++)
                cfg_mem[i] <= 8'h00;
        end
        else
        begin
            if (tbl_fen)
                fen_reg[tbl_wr_i.index] <= tbl_wr_i.data[0];
            if (tbl_ien)
                ien_reg[tbl_wr_i.index] <= tbl_wr_i.data[0];
            if (tbl_cfg)
                cfg_mem[tbl_wr_i.index[2:0]] <= tbl_wr_i.data[7:0];
        end
    end

    // =========================================================
    // Acceptance scan, lowest filter number first.
    // =========================================================
    crfs_scan_t          scan_state_reg;
    crfs_frame_t         frame_reg;
    logic [7:0]          scan_idx_reg;
    wire [KEY_BITS-1:0]  frame_key = {frame_reg.ident, frame_reg.data[63:48]};
    wire [KEY_BITS-1:0]  miss_bits = (frame_key ^ match_mem[scan_idx_reg])
                                     & mask_mem[scan_idx_reg];
    wire hit   = (scan_state_reg == SCAN_RUN) && fen_reg[scan_idx_reg]
                 && (miss_bits == '0);
    wire store = hit;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            scan_state_reg <= SCAN_IDLE;
            frame_reg      <= '0;
            scan_idx_reg   <= 8'h00;
        end
        else
        begin
            case (scan_state_reg)
                SCAN_IDLE:
                    if (frame_done)
                    begin
                        frame_reg      <= crfs_frame_t'(rx_shift_reg);
                        scan_idx_reg   <= 8'h00;
                        scan_state_reg <= SCAN_RUN;
                    end
                SCAN_RUN:
                begin
                    if (hit || scan_idx_reg == 8'(FILTERS - 1))
                        scan_state_reg <= SCAN_IDLE;
                    else
                        scan_idx_reg <= scan_idx_reg + 8'h01;
                end
                default:
                    scan_state_reg <= SCAN_IDLE;
            endcase
        end
    end

    // =========================================================
    // Receive data memory and status bytes.
    // =========================================================
    logic [FRAME_BITS-1:0] blk_mem    [FILTERS];
    logic [7:0]            status_reg [FILTERS];

    always_ff @(posedge clk_sys_i)
    begin
        if (store)
            blk_mem[scan_idx_reg] <= frame_reg;
    end

    wire host_clr  = host_rd_i.valid && (host_rd_i.cmd == HOST_READ_CMD);
    wire sched_any = |sched_rd_i.who;

    genvar g;
    generate
        for (g = 0; g < FILTERS; g++)
        begin : g_status
            wire       set_new = store && (scan_idx_reg == 8'(g));
            wire [7:0] clr_h   = (host_clr && host_rd_i.block == 8'(g))
                                 ? (8'h01 << HOST_UNREAD_BIT) : 8'h00;
            wire [7:0] clr_s   = (sched_any && sched_rd_i.block == 8'(g))
                                 ? {3'h0, sched_rd_i.who} : 8'h00;
            always_ff @(posedge clk_sys_i)
            begin
                if (rst_i)
                    status_reg[g] <= STATUS_RESET;
                else if (set_new)
                    status_reg[g] <= STATUS_NEW_ALL;
                else
                    status_reg[g] <= status_reg[g] & ~(clr_h | clr_s);
            end
        end
    endgenerate

    // Byte 0 of a block is the status byte, bytes 1..15 the frame.
    function automatic logic [7:0] blk_byte(input logic [7:0] st,
                                            input logic [FRAME_BITS-1:0] fr,
                                            input logic [3:0] offs);
        logic [7:0] b;
        b = st;
        if (offs != STATUS_OFFS)
            b = fr[FRAME_BITS - 8 * int'(offs) +: 8];
        return b;
    endfunction

    wire [7:0] host_byte  = blk_byte(status_reg[host_rd_i.block],
                                     blk_mem[host_rd_i.block], host_rd_i.offs);
    wire [7:0] sched_byte = blk_byte(status_reg[sched_rd_i.block],
                                     blk_mem[sched_rd_i.block], sched_rd_i.offs);

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            host_rd_data_o  <= 8'h00;
            sched_rd_data_o <= 8'h00;
        end
        else
        begin
            if (host_rd_i.valid)
                host_rd_data_o <= host_byte;
            if (sched_any)
                sched_rd_data_o <= sched_byte;
        end
    end

    // =========================================================
    // CAN receive interrupt.
    // =========================================================
    logic       pend_reg;
    logic [7:0] int_addr_reg;
    wire int_event = store && ien_reg[scan_idx_reg];
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            pend_reg     <= 1'b0;
            int_addr_reg <= 8'h00;
        end
        else
        begin
            if (int_event)
                pend_reg <= 1'b1;
            else if (can_int_clr_i)
                pend_reg <= 1'b0;
            if (int_event && !can_int_mask_i)
                int_addr_reg <= scan_idx_reg;
        end
    end

    assign can_int_pend_o = pend_reg;
    assign int_o          = pend_reg && !can_int_mask_i;
    assign int_addr_o     = int_addr_reg;

    // =========================================================
    // Configuration download after a rising edge of run.
    // =========================================================
    logic [CFG_BITS-1:0] tx_shift_reg;
    logic [6:0]          tx_bits_reg;
    logic [3:0]          tx_div_reg;
    logic                tx_busy_reg;
    logic                tx_sck_reg;
    logic [CFG_BITS-1:0] cfg_flat;
    always_comb
    begin
        cfg_flat = '0;
        for (int i = 0; i < CFG_BYTES; i++)
            cfg_flat[CFG_BITS - 8 * (i + 1) +: 8] = cfg_mem[i];
    end

    wire tx_tick = tx_busy_reg && (tx_div_reg == 4'(LINK_HALF_CYC - 1));
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            tx_shift_reg <= '0;
            tx_bits_reg  <= 7'h00;
            tx_div_reg   <= 4'h0;
            tx_busy_reg  <= 1'b0;
            tx_sck_reg   <= 1'b0;
        end
        else if (!tx_busy_reg)
        begin
            if (run_rise)
            begin
                tx_shift_reg <= cfg_flat;
                tx_bits_reg  <= 7'(CFG_BITS);
                tx_div_reg   <= 4'h0;
                tx_busy_reg  <= 1'b1;
            end
        end
        else if (tx_tick)
        begin
            tx_div_reg <= 4'h0;
            tx_sck_reg <= ~tx_sck_reg;
            if (tx_sck_reg)
            begin
                tx_shift_reg <= {tx_shift_reg[CFG_BITS-2:0], 1'b0};
                tx_bits_reg  <= tx_bits_reg - 7'h01;
                if (tx_bits_reg == 7'h01)
                    tx_busy_reg <= 1'b0;
            end
        end
        else
            tx_div_reg <= tx_div_reg + 4'h1;
    end

    assign cfg_sck_o  = tx_sck_reg;
    assign cfg_cs_n_o = ~tx_busy_reg;
    assign cfg_sdo_o  = tx_shift_reg[CFG_BITS-1];

endmodule // crfs_top

// [dv/crfs_props.sv]
`timescale 1ns/1ps
// ==========================================================
// Port-level checks of the frame store and its links.
module crfs_props
    import crfs_pkg::*;
(
    input wire logic                     clk_sys_i,
    input wire logic                     rst_i,
    input wire logic                     run_i,
    input wire logic                     cfg_sck_o,
    input wire logic                     cfg_cs_n_o,
    input wire logic                     cfg_sdo_o,
    input wire crfs_pkg::crfs_host_rd_t  host_rd_i,
    input wire logic [7:0]               host_rd_data_o,
    input wire crfs_pkg::crfs_sched_rd_t sched_rd_i,
    input wire logic [7:0]               sched_rd_data_o,
    input wire logic                     can_int_mask_i,
    input wire logic                     can_int_clr_i,
    input wire logic                     can_int_pend_o,
    input wire logic                     int_o,
    input wire logic [7:0]               int_addr_o
);
    wire logic host_st  = host_rd_i.valid && (host_rd_i.offs == STATUS_OFFS);
    wire logic sched_st = (|sched_rd_i.who) && (sched_rd_i.offs == STATUS_OFFS);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_int_follows_pend: assert property (int_o == (can_int_pend_o && !can_int_mask_i))
        else $error("int_o disagrees with pending bit and mask");
    a_addr_load_unmasked: assert property ($changed(int_addr_o) |-> can_int_pend_o && !$past(can_int_mask_i))
        else $error("int_addr_o changed without an unmasked interrupt");
    a_pend_clear_cause: assert property ($fell(can_int_pend_o) |-> $past(can_int_clr_i))
        else $error("pending bit fell without a clear");
    a_cfg_idle_low: assert property (cfg_cs_n_o |-> !cfg_sck_o)
        else $error("config clock moved while deselected");
    a_run_starts_cfg: assert property ($rose(run_i) && cfg_cs_n_o |-> ##[1:6] !cfg_cs_n_o)
        else $error("run edge did not start the config download");
    a_cfg_cs_span: assert property ($fell(cfg_cs_n_o) |-> !cfg_cs_n_o [*8])
        else $error("config select too short");
    a_cfg_sck_half: assert property ($rose(cfg_sck_o) |-> cfg_sck_o [*7] ##1 !cfg_sck_o)
        else $error("config clock high phase not seven cycles");
    a_sdo_stable_high: assert property (cfg_sck_o && $past(cfg_sck_o) |-> $stable(cfg_sdo_o))
        else $error("config data moved while clock high");
    a_host_top_zero: assert property ($past(host_st) |-> host_rd_data_o[7:6] == 2'b00)
        else $error("host status read shows bits 7:6 set");
    a_sched_top_zero: assert property ($past(sched_st) |-> sched_rd_data_o[7:6] == 2'b00)
        else $error("scheduler status read shows bits 7:6 set");

    c_pend_rise: cover property ($rose(can_int_pend_o));
    c_cfg_start: cover property ($fell(cfg_cs_n_o));
    c_addr_load: cover property ($changed(int_addr_o));
endmodule // crfs_props

bind crfs_top crfs_props u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run_i),
    .cfg_sck_o(cfg_sck_o), .cfg_cs_n_o(cfg_cs_n_o), .cfg_sdo_o(cfg_sdo_o),
    .host_rd_i(host_rd_i), .host_rd_data_o(host_rd_data_o), .sched_rd_i(sched_rd_i),
    .sched_rd_data_o(sched_rd_data_o), .can_int_mask_i(can_int_mask_i),
    .can_int_clr_i(can_int_clr_i), .can_int_pend_o(can_int_pend_o), .int_o(int_o),
    .int_addr_o(int_addr_o));

// [dv/crfs_chip_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Far-end CAN controller: sends frames, captures config bits.
module crfs_chip_model
    import crfs_pkg::*;
(
    input  wire logic cfg_sck_i,
    input  wire logic cfg_cs_n_i,
    input  wire logic cfg_sdo_i,
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      sdi_o
);
    logic [63:0] cfg_seen = 64'h0;
    int          cfg_cnt  = 0;

    initial
    begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b1;
    end

    // Clock stands low between frames; the released data line flips.
    task automatic send_frame(input crfs_frame_t f);
        cs_n_o = 1'b0;
        for (int i = FRAME_BITS - 1; i >= 0; i--)
        begin
            sdi_o = f[i];
            #62.5 sck_o = 1'b1;
            #62.5 sck_o = 1'b0;
        end
        #60 cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #100;
    endtask

    always @(posedge cfg_sck_i)
    begin
        if (!cfg_cs_n_i)
        begin
            cfg_seen = {cfg_seen[62:0], cfg_sdo_i};
            cfg_cnt  = cfg_cnt + 1;
        end
    end
endmodule // crfs_chip_model

// [dv/crfs_tb.sv]
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the frame filter and store.
module testbench;
    import crfs_pkg::*;

    localparam logic [47:0] KEY_A = {32'h1ABC_5678, 16'hBEEF};
    localparam logic [47:0] KEY_B = {32'h1ABC_0001, 16'h0000};
    localparam logic [47:0] KEY_C = {32'h0ABC_0001, 16'h0000};
    localparam logic [47:0] ALL   = 48'hFFFF_FFFF_FFFF;
    localparam logic [63:0] CFG   = 64'h5A3C_96E1_0FF0_A55A;

    logic           clk_sys_i = 1'b0;
    logic           rst_i = 1'b1, run_i = 1'b0, mask = 1'b0, clr = 1'b0;
    logic           rx_sck, rx_cs_n, rx_sdi, cfg_sck, cfg_cs_n, cfg_sdo, pend, int_o;
    logic [7:0]     host_d, sched_d, int_addr;
    crfs_tbl_wr_t   tbl_wr = '0;
    crfs_host_rd_t  host_rd = '0;
    crfs_sched_rd_t sched_rd = '0;
    int             fails = 0, num_checks = 0, cycles = 0;

    crfs_top dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run_i), .rx_sck_i(rx_sck),
        .rx_cs_n_i(rx_cs_n), .rx_sdi_i(rx_sdi), .cfg_sck_o(cfg_sck), .cfg_cs_n_o(cfg_cs_n),
        .cfg_sdo_o(cfg_sdo), .tbl_wr_i(tbl_wr), .host_rd_i(host_rd), .host_rd_data_o(host_d),
        .sched_rd_i(sched_rd), .sched_rd_data_o(sched_d), .can_int_mask_i(mask),
        .can_int_clr_i(clr), .can_int_pend_o(pend), .int_o(int_o), .int_addr_o(int_addr));
    crfs_chip_model chip (.cfg_sck_i(cfg_sck), .cfg_cs_n_i(cfg_cs_n), .cfg_sdo_i(cfg_sdo),
        .sck_o(rx_sck), .cs_n_o(rx_cs_n), .sdi_o(rx_sdi));

    always #5 clk_sys_i = ~clk_sys_i;

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fails++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tbl(input logic [2:0] s, input logic [7:0] n, input logic [47:0] v);
        @(negedge clk_sys_i);
        tbl_wr <= '{1'b1, s, n, v};
        @(negedge clk_sys_i);
        tbl_wr.valid <= 1'b0;
    endtask

    task automatic filt(input logic [7:0] n, input logic [47:0] m, input logic [47:0] k,
                        input logic en, input logic ie);
        tbl(TBL_MATCH, n, m);
        tbl(TBL_MASK, n, k);
        tbl(TBL_IEN, n, {47'h0, ie});
        tbl(TBL_FEN, n, {47'h0, en});
    endtask

    task automatic hrd(input logic [7:0] c, input logic [7:0] b, input logic [3:0] o,
                       output logic [7:0] d);
        @(negedge clk_sys_i);
        host_rd <= '{1'b1, c, b, o};
        @(negedge clk_sys_i);
        host_rd.valid <= 1'b0;
        d = host_d;
    endtask

    task automatic srd(input logic [4:0] w, input logic [7:0] b, input logic [3:0] o,
                       output logic [7:0] d);
        @(negedge clk_sys_i);
        sched_rd <= '{w, b, o};
        @(negedge clk_sys_i);
        sched_rd.who <= 5'h00;
        d = sched_d;
    endtask

    task automatic rd(input logic [7:0] b, input logic [3:0] o, input logic [7:0] e, string nm);
        logic [7:0] d;
        hrd(8'h00, b, o, d);
        chk(nm, e, d);
    endtask

    task automatic pulse_clr();
        @(negedge clk_sys_i);
        clr <= 1'b1;
        @(negedge clk_sys_i);
        clr <= 1'b0;
        @(negedge clk_sys_i);
    endtask

    function automatic crfs_frame_t mkf(input logic [47:0] k, input logic [15:0] s);
        return '{k[47:16], 8'h08, {k[15:0], 32'h1122_3344, s}, s};
    endfunction

    task automatic rx(input crfs_frame_t f);
        chip.send_frame(f);
        repeat (300) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    task automatic t_reset();
        rd(8'h00, STATUS_OFFS, 8'h00, "status 0");
        rd(8'hFF, STATUS_OFFS, 8'h00, "status 255");
        chk("int_o", 8'h00, {7'h0, int_o});
        chk("int_addr", 8'h00, int_addr);
    endtask

    task automatic t_accept();
        crfs_frame_t f;
        f = mkf(KEY_A, 16'h0101);
        filt(8'd3, KEY_A, ALL, 1'b0, 1'b1);
        filt(8'd5, KEY_A, ALL, 1'b1, 1'b1);
        filt(8'd9, {32'h1ABC_0000, 16'h0}, 48'hFFFF_0000_0000, 1'b1, 1'b0);
        rx(f);
        chk("pend", 8'h01, {7'h0, pend});
        chk("int_o", 8'h01, {7'h0, int_o});
        chk("int_addr", 8'h05, int_addr);
        rd(8'd5, STATUS_OFFS, 8'h3F, "status 5");
        rd(8'd3, STATUS_OFFS, 8'h00, "status 3");
        rd(8'd9, STATUS_OFFS, 8'h00, "status 9");
        for (int i = 1; i < 16; i++)
            rd(8'd5, 4'(i), f[FRAME_BITS - 8 * i +: 8], "byte 5");
        pulse_clr();
        chk("pend cleared", 8'h00, {7'h0, pend});
    endtask

    task automatic t_mask();
        rx(mkf(KEY_B, 16'h0202));
        rd(8'd9, STATUS_OFFS, 8'h3F, "status 9");
        chk("pend", 8'h00, {7'h0, pend});
        rx(mkf(KEY_C, 16'h0303));
        rd(8'd9, 4'hF, 8'h02, "stamp 9");
    endtask

    task automatic t_flags();
        logic [7:0] d;
        hrd(HOST_READ_CMD, 8'd5, STATUS_OFFS, d);
        chk("first read", 8'h3F, d);
        rd(8'd5, STATUS_OFFS, 8'h1F, "after host");
        rd(8'd5, STATUS_OFFS, 8'h1F, "other cmd");
        srd(5'h10, 8'd5, 4'h7, d);
        chk("sched byte", KEY_A[7:0], d);
        rd(8'd5, STATUS_OFFS, 8'h0F, "after can");
        for (int n = 0; n < 4; n++)
        begin
            srd(5'(1 << n), 8'd5, STATUS_OFFS, d);
            chk("sched status", 8'h0F & ~8'((1 << n) - 1), d);
            rd(8'd5, STATUS_OFFS, 8'h0F & ~8'((2 << n) - 1), "after arinc");
        end
    endtask

    task automatic t_overwrite();
        tbl(TBL_IEN, 8'd9, 48'h0000_0000_0001);
        mask <= 1'b1;
        chip.send_frame(mkf(KEY_A, 16'h0404));
        rx(mkf(KEY_B, 16'h0505));
        rd(8'd5, STATUS_OFFS, 8'h3F, "rewrite 5");
        rd(8'd5, 4'hF, 8'h04, "stamp 5");
        rd(8'd9, 4'hF, 8'h05, "stamp 9");
        chk("pend", 8'h01, {7'h0, pend});
        chk("int_o masked", 8'h00, {7'h0, int_o});
        chk("int_addr", 8'h05, int_addr);
        mask <= 1'b0;
        @(negedge clk_sys_i);
        chk("int_o unmasked", 8'h01, {7'h0, int_o});
        pulse_clr();
    endtask

    task automatic t_config();
        for (int i = 0; i < CFG_BYTES; i++)
            tbl(TBL_CFG, 8'(i), {40'h0, CFG[63 - 8 * i -: 8]});
        run_i <= 1'b1;
        for (int t = 0; t < 20 && cfg_cs_n; t++) @(posedge clk_sys_i);
        chk("cfg start", 8'h00, {7'h0, cfg_cs_n});
        for (int t = 0; t < 1200 && !cfg_cs_n; t++) @(posedge clk_sys_i);
        chk("cfg bits", 8'd64, 8'(chip.cfg_cnt));
        for (int i = 0; i < CFG_BYTES; i++)
            chk("cfg byte", CFG[63 - 8 * i -: 8], chip.cfg_seen[63 - 8 * i -: 8]);
    endtask

    initial
    begin
        repeat (6) @(negedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_accept();
        t_mask();
        t_flags();
        t_overwrite();
        t_config();
        final_report();
    end
endmodule // testbench
